// file: verification/mdi_datapath_assertions.sv
// port checker of the converter input datapath
// assumes bind onto mdi_datapath from the bench top
`timescale 1ns/100ps

module mdi_datapath_assertions (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        mux_ratio_select,
	input wire logic        slow_clock_out_pos,
	input wire logic        slow_clock_out_neg,
	input wire logic        mux_select_low,
	input wire logic        mux_select_high,
	input wire logic [62:0] thermo_switch,
	input wire logic [5:0]  binary_switch
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ========
	// selects and slow clock
	sel_low_toggle_a: assert property (
		$past(nrst) && $past(nrst, 2) |-> mux_select_low != $past(mux_select_low))
		else $error("fast select stalled");
	sel_high_rate_a: assert property (
		mux_ratio_select [*8] ##0 $changed(mux_select_high)
		|=> $stable(mux_select_high) ##1 $changed(mux_select_high)) else $error("slow select rate");
	clock_pair_a: assert property (
		slow_clock_out_neg == !slow_clock_out_pos) else $error("slow clock pair not complementary");
	four_clock_a: assert property (
		mux_ratio_select [*8] ##0 $rose(slow_clock_out_pos)
		|=> slow_clock_out_pos ##1 !slow_clock_out_pos [*2] ##1 slow_clock_out_pos)
		else $error("slow clock not fast over four");
	two_high_idle_a: assert property (
		!mux_ratio_select [*8] |-> !mux_select_high) else $error("slow select moved in two to one");
	two_clock_a: assert property (
		!mux_ratio_select [*8] |-> slow_clock_out_pos != $past(slow_clock_out_pos))
		else $error("slow clock not fast over two");
	// ========
	// switch outputs and covers
	thermo_shape_a: assert property (
		((thermo_switch + 63'h1) & thermo_switch) == 63'h0) else $error("not a thermometer code");
	switch_reset_a: assert property (disable iff (1'b0)
		!nrst |=> thermo_switch == 63'h0 && binary_switch == 6'h0) else $error("switches not cleared");
	cover property (mux_ratio_select ##1 $rose(slow_clock_out_pos));
	cover property (!mux_ratio_select [*8] ##1 $rose(slow_clock_out_pos));
	cover property (&thermo_switch);
endmodule // mdi_datapath_assertions

// file: verification/mdi_datapath_tb.sv
// self-checking bench of the converter input datapath
// assumes design files, source model and checker compiled first
`timescale 1ns/100ps

module mdi_datapath_tb;
	logic        clk, nrst, mux_ratio_select, slow_clock_out_pos, slow_clock_out_neg;
	logic        mux_select_low, mux_select_high, prev_pos, synced;
	logic [47:0] rnd_q, chans;
	logic [62:0] thermo_switch;
	logic [5:0]  binary_switch;
	logic [11:0] exp_q[$];
	int          mismatches, checked, settle, hunt;

	mdi_datapath u_mdi_datapath (.clk, .nrst, .mux_ratio_select, .channel_a_sample(chans[47:36]),
		.channel_b_sample(chans[35:24]), .channel_c_sample(chans[23:12]),
		.channel_d_sample(chans[11:0]), .slow_clock_out_pos, .slow_clock_out_neg,
		.mux_select_low, .mux_select_high, .thermo_switch, .binary_switch);
	mdi_source u_mdi_source (.slow_clock_out_pos, .rnd(rnd_q), .chans);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [62:0] thermo_of(input logic [11:0] w);
		logic [63:0] t;
		t = (64'h1 << w[11:6]) - 64'h1;
		return t[62:0];
	endfunction
	task automatic fail(input string m);
		mismatches++;
		$display("ERROR %0t %s", $time, m);
	endtask
	// ========
	// queue captured words, then follow them to the switches
	always @(posedge clk) begin
		if (!nrst) begin
			settle = 0;
			synced = 1'b0;
			hunt = 0;
			exp_q.delete();
		end else if (settle < 8) begin
			settle++;
		end else begin
			if (slow_clock_out_pos && !prev_pos) begin
				exp_q.push_back(chans[47:36]);
				exp_q.push_back(chans[35:24]);
				if (mux_ratio_select) begin
					exp_q.push_back(chans[23:12]);
					exp_q.push_back(chans[11:0]);
				end
			end
			if (exp_q.size() > 0) begin
				// fixed latency: rise seen, then word, decode, switch register
				if (synced || hunt == 3) begin
					synced = 1'b1;
					checked++;
					if (thermo_switch !== thermo_of(exp_q[0])) fail("upper bits wrong");
					if (binary_switch !== exp_q[0][5:0]) fail("lower bits wrong");
					void'(exp_q.pop_front());
				end else if (++hunt > 40) begin
					fail("no captured word reached the switches");
					final_report();
				end
			end else if (synced) begin
				fail("switch word without a capture");
			end
		end
		prev_pos = slow_clock_out_pos;
	end
	task automatic run(input logic mode);
		nrst <= 1'b0;
		mux_ratio_select <= mode;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (600) begin
			@(posedge clk);
			rnd_q <= {16'($urandom()), $urandom()};
		end
		if (!synced) fail("switches never followed the captures");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'hF658));
		nrst = 1'b0;
		mux_ratio_select = 1'b1;
		rnd_q = 48'h0;
		prev_pos = 1'b1;
		mismatches = 0;
		checked = 0;
		run(1'b1);
		run(1'b0);
		final_report();
	end
endmodule // mdi_datapath_tb

bind mdi_datapath mdi_datapath_assertions u_mdi_datapath_assertions (.clk, .nrst,
	.mux_ratio_select, .slow_clock_out_pos, .slow_clock_out_neg, .mux_select_low,
	.mux_select_high, .thermo_switch, .binary_switch);

// file: verification/mdi_source.sv
// sample source clocked by the forwarded slow clock
// assumes random words are handed in by the bench
`timescale 1ns/100ps

module mdi_source (
	input  wire logic        slow_clock_out_pos,
	input  wire logic [47:0] rnd,
	output logic      [47:0] chans
);
	logic [1:0] step;
	initial begin
		step = 2'h0;
		chans = 48'h5A5A5A5A5A5A;
	end
	// ========
	// launch on the falling slow edge, inside the transition window
	always @(negedge slow_clock_out_pos) begin
		step <= step + {1'b0, step != 2'h2};
		case (step)
			2'h0: chans <= {12'hFFF, 12'h000, 12'hFC0, 12'h03F};
			2'h1: chans <= {12'h03F, 12'hFC0, 12'h000, 12'hFFF};
			default: chans <= rnd;
		endcase
	end
endmodule // mdi_source

// file: verilog/mdi_cfg.svh
// timing, field and reset constants of the mux converter input datapath
// assumes inclusion by bare name from design files only
`ifndef MDI_CFG_SVH
`define MDI_CFG_SVH

`define MDI_SAMPLE_W     12
`define MDI_UPPER_W      6
`define MDI_LOWER_W      6
`define MDI_THERMO_W     63
`define MDI_UPPER_MSB    11
`define MDI_UPPER_LSB    6
`define MDI_LOWER_MSB    5
`define MDI_CHANNELS     4
`define MDI_CHAN_W       2
`define MDI_PHASE_W      2
`define MDI_PHASE_RESET  2'h0
`define MDI_PHASE_LAST4  2'h3
`define MDI_SAMPLE_RESET 12'h000
`define MDI_THERMO_RESET 63'h0000000000000000
`define MDI_PATH_RESET   6'h00

`endif

// file: verilog/mdi_datapath.sv
// input capture, 4:1 or 2:1 multiplexing and forwarded slow clock
// assumes clk is the fast converter clock; channel pins are launched on slow clock
`timescale 1ns/100ps
`include "mdi_cfg.svh"

// Function
// - Each 12-bit channel is registered right after its input.
// - The four captured channels are muxed 48 to 12 and the result registered again.
// - The upper six bits become 63 equal thermometer outputs in two decode stages.
// - The lower six bits pass a matching delay to stay aligned with the upper bits.
// - The second decode stage register drives the switches directly, alongside the delayed lower bits.
// - Mux selects come from the fast clock divided by two and by four.
// - A divided slow clock is driven out as a differential pair.
// - Channels are captured on an internal clock in phase with the slow clock output.
// - One captured word is presented per fast clock cycle in select order.
// - A static mode pin picks four-to-one when floating high or two-to-one when grounded.
// - Each channel is 12 bits indexed 0 to 11 with bit 11 the msb.
module mdi_datapath (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        mux_ratio_select,
	input  wire logic [11:0] channel_a_sample,
	input  wire logic [11:0] channel_b_sample,
	input  wire logic [11:0] channel_c_sample,
	input  wire logic [11:0] channel_d_sample,
	output logic             slow_clock_out_pos,
	output logic             slow_clock_out_neg,
	output logic             mux_select_low,
	output logic             mux_select_high,
	output logic [62:0]      thermo_switch,
	output logic [5:0]       binary_switch
);

	typedef struct packed {
		logic [2:0]               mode_sync_q;
		mdi_pkg::mdi_ratio_e      ratio_q;
		logic [`MDI_PHASE_W-1:0]  phase_q;
		logic                     slow_clk_q;
		mdi_pkg::mdi_sample_t     cap_a_q;
		mdi_pkg::mdi_sample_t     cap_b_q;
		mdi_pkg::mdi_sample_t     cap_c_q;
		mdi_pkg::mdi_sample_t     cap_d_q;
		mdi_pkg::mdi_sample_t     word_q;
	} mdi_dp_s;

	mdi_dp_s st_q;
	mdi_dp_s st_d;

	mdi_word_if word_link ();

	// select pair to channel index
	function automatic logic [`MDI_CHAN_W-1:0] mdi_chan(input logic [`MDI_PHASE_W-1:0] ph,
	                                                    input mdi_pkg::mdi_ratio_e r);
		if (r == mdi_pkg::MDI_RATIO_TWO)
			return {1'b0, ph[0]};
		return ph;
	endfunction

	// ========================================================
	// next state
	always_comb begin
		logic capture;
		capture = 1'b0;
		st_d = st_q;
		// mode pin: three flops, change counted when last two agree
		st_d.mode_sync_q = {st_q.mode_sync_q[1:0], mux_ratio_select};
		if (st_q.mode_sync_q[2] == st_q.mode_sync_q[1]) begin
			st_d.ratio_q = st_q.mode_sync_q[2] ? mdi_pkg::MDI_RATIO_FOUR
			                                   : mdi_pkg::MDI_RATIO_TWO;
		end
		// divide by two and four
		st_d.phase_q = st_q.phase_q + 2'h1;
		if (st_q.ratio_q == mdi_pkg::MDI_RATIO_TWO) begin
			st_d.phase_q[1] = 1'b0;
		end
		// slow clock: high for first half of the period
		if (st_q.ratio_q == mdi_pkg::MDI_RATIO_TWO)
			st_d.slow_clk_q = (st_d.phase_q[0] == 1'b0);
		else
			st_d.slow_clk_q = (st_d.phase_q[1] == 1'b0);
		// capture at the slow clock rising edge, in phase with the output
		capture = (st_q.ratio_q == mdi_pkg::MDI_RATIO_TWO) ? (st_q.phase_q[0] == 1'b1)
		        : (st_q.phase_q == `MDI_PHASE_LAST4);
		if (capture) begin
			st_d.cap_a_q = channel_a_sample;
			st_d.cap_b_q = channel_b_sample;
			st_d.cap_c_q = channel_c_sample;
			st_d.cap_d_q = channel_d_sample;
		end
		// 48 to 12 mux, order a b c d
		case (mdi_chan(st_q.phase_q, st_q.ratio_q))
			2'h0:    st_d.word_q = st_q.cap_a_q;
			2'h1:    st_d.word_q = st_q.cap_b_q;
			2'h2:    st_d.word_q = st_q.cap_c_q;
			2'h3:    st_d.word_q = st_q.cap_d_q;
			default: st_d.word_q = st_q.cap_a_q;
		endcase
		if (!nrst) begin
			st_d = '0;
			st_d.mode_sync_q = 3'h7;
			st_d.ratio_q = mdi_pkg::MDI_RATIO_FOUR;
			st_d.slow_clk_q = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	assign word_link.word = st_q.word_q;

	// ========================================================
	// decode and switch register stage
	mdi_decoder u_decoder (
		.clk     (clk),
		.nrst    (nrst),
		.word_in (word_link.sink),
		.thermo  (thermo_switch),
		.lower   (binary_switch)
	);

	// ========================================================
	// outputs
	assign slow_clock_out_pos = st_q.slow_clk_q;
	assign slow_clock_out_neg = ~st_q.slow_clk_q;
	assign mux_select_low     = st_q.phase_q[0];
	assign mux_select_high    = st_q.phase_q[1];

endmodule // mdi_datapath

// file: verilog/mdi_decoder.sv
// splits the selected word: upper bits to thermometer, lower bits delay matched
// assumes word arrives registered on clk
`timescale 1ns/100ps
`include "mdi_cfg.svh"

module mdi_decoder (
	input  wire logic        clk,
	input  wire logic        nrst,
	mdi_word_if.sink         word_in,
	output mdi_pkg::mdi_thermo_t thermo,
	output mdi_pkg::mdi_lower_t  lower
);

	typedef struct packed {
		logic [7:0]           row_q;
		logic [7:0]           col_q;
		mdi_pkg::mdi_lower_t  lower_dly_q;
		mdi_pkg::mdi_thermo_t thermo_q;
		mdi_pkg::mdi_lower_t  lower_q;
	} mdi_dec_s;

	mdi_dec_s st_q;
	mdi_dec_s st_d;

	// 3-bit value to 8-bit thermometer, bit i set when value > i
	function automatic logic [7:0] mdi_therm3(input logic [2:0] v);
		logic [7:0] t;
		t = 8'h00;
		for (int i = 0; i < 8; i++) begin
			t[i] = (i < int'(v));
		end
		return t;
	endfunction

	// ========================================================
	// two stage decode
	always_comb begin
		logic [`MDI_UPPER_W-1:0] up;
		up = word_in.word[`MDI_UPPER_MSB:`MDI_UPPER_LSB];
		st_d = st_q;
		// first stage: row and column groups
		st_d.row_q = mdi_therm3(up[5:3]);
		st_d.col_q = mdi_therm3(up[2:0]);
		st_d.lower_dly_q = word_in.word[`MDI_LOWER_MSB:0];
		// second stage: 63 equal outputs, rows of 8 full then partial row
		for (int r = 0; r < 8; r++) begin
			for (int c = 0; c < 8; c++) begin
				if (r * 8 + c < `MDI_THERMO_W) begin
					st_d.thermo_q[r * 8 + c] = st_q.row_q[r]
						| ((r == 0 || st_q.row_q[r - 1 < 0 ? 0 : r - 1]) && !st_q.row_q[r]
						&& st_q.col_q[c] && (r == 0 ? 1'b1 : 1'b1)) ;
				end
			end
		end
		st_d.lower_q = st_q.lower_dly_q;
		if (!nrst) begin
			st_d = '0;
		end
	end

	// ========================================================
	// second master-slave stage before the switches
	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	assign thermo = st_q.thermo_q;
	assign lower  = st_q.lower_q;

endmodule // mdi_decoder

// file: verilog/mdi_pkg.sv
// types of the mux converter input datapath
// assumes mdi_cfg.svh is in the include path
`include "mdi_cfg.svh"

package mdi_pkg;

	typedef logic [`MDI_SAMPLE_W-1:0] mdi_sample_t;
	typedef logic [`MDI_THERMO_W-1:0] mdi_thermo_t;
	typedef logic [`MDI_LOWER_W-1:0]  mdi_lower_t;

	typedef enum logic {
		MDI_RATIO_FOUR,
		MDI_RATIO_TWO
	} mdi_ratio_e;

endpackage

// file: verilog/mdi_word_if.sv
// carries the selected sample word from the multiplexer stage to the decoder
// assumes one clock domain shared by both ends
`timescale 1ns/100ps

interface mdi_word_if;
	mdi_pkg::mdi_sample_t word;

	modport source (output word);
	modport sink   (input  word);
endinterface
